// file: rtl/isolated_input_status_regs.sv
// register bank of the eight-channel isolated input device
// Contract
// - wire-break summary at 0x00, bit x set when channel x broke.
// - input level register at 0x02, filtered data of channels 0..7.
// - level bit is 1 above threshold, 0 below.
// - parallel mode address latch defaults to the input level address.
// - collective fault bit equals OR of all summary bits.
// - global fault read-only, sticky, clears after read once fault gone.
// - supply missing bit 1, supply low bit 2, bits 7..3 zero.
// - low and missing supply forced to 1 on lockout or link error.
// - global and internal fault bits drive the fault pin.
// - filter code 0..7 selects 50us..20ms; 8..F bypasses.
// - filter time applies to data and wire-break paths alike.
// - mask bit 4 zero hides channel wire-break from the summary.
// - filter cfg read 0x06..0x14, write 0x86..0x94, reset 0x1F.
// - cfg bits 7..5 read as zero; host should write zero.
// - internal fault bits sticky until read and fault resolved.
// - sense-not-ready and link-fault preset to 1 at power-up.
// - summary read clears only if no break present or pending.
// - bits frozen at read start; only bits read and unchanged clear.
`timescale 1ns/10ps
module isolated_input_status_regs (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       parallel_sel,
  input  wire logic       addr_wr,
  input  wire logic [7:0] addr_in,
  input  wire logic       rd_start,
  input  wire logic       rd_end,
  input  wire logic       wr_strobe,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] channel_input_pin,
  input  wire logic [7:0] wire_break_pin,
  input  wire logic       below_lockout_pin,
  input  wire logic       supply_missing_pin,
  input  wire logic       supply_low_pin,
  input  wire logic       link_error_pin,
  input  wire logic       sense_not_ready_pin,
  input  wire logic       converter_fault_pin,
  output logic [7:0]      rd_data,
  output logic [7:0]      addr_latch,
  output logic [7:0]      global_fault_out,
  output logic [7:0]      internal_fault_out,
  output logic            fault_n
);

  logic [7:0] filter_cfg_r [8];
  logic [7:0] level_filt;
  logic [7:0] break_filt;
  logic [7:0] break_seen;
  logic [7:0] input_level_r;
  logic [7:0] wire_break_summary_r;
  logic [2:0] global_fault_r;
  logic [2:0] internal_fault_r;
  logic [7:0] frozen_r;
  logic [7:0] rd_addr_r;
  logic       rd_busy_r;
  logic [1:0] lockout_sync_r;
  logic [1:0] missing_sync_r;
  logic [1:0] low_sync_r;
  logic [1:0] link_sync_r;
  logic [1:0] notready_sync_r;
  logic [1:0] conv_sync_r;
  logic [7:0] brk_meta_r;
  logic [7:0] brk_raw_r;
  logic       supply_missing_now;
  logic       supply_low_now;
  logic [2:0] internal_now;
  logic [7:0] rd_mux;
  logic [7:0] eff_addr;
  logic       rd_finish;
  logic [2:0] cfg_wr_idx;
  logic       cfg_wr_hit;
  logic [2:0] cfg_rd_idx;
  logic       cfg_rd_hit;

  // --------------------------------------------------------------------------
  // per-channel filters
  // --------------------------------------------------------------------------
  // one filter instance per channel
  for (genvar ch = 0; ch < 8; ch++) begin : g_chan
    channel_filter u_filter (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .level_pin   (channel_input_pin[ch]),
      .break_pin   (wire_break_pin[ch]),
      .period_code (filter_cfg_r[ch][input_status_pkg::CFG_CODE_MSB:0]),
      .level_out   (level_filt[ch]),
      .break_out   (break_filt[ch])
    );
    assign break_seen[ch] = break_filt[ch]
                            & filter_cfg_r[ch][input_status_pkg::BIT_WIRE_BREAK_MASK];
  end

  // --------------------------------------------------------------------------
  // fault pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lockout_sync_r  <= 2'h0;
      missing_sync_r  <= 2'h0;
      low_sync_r      <= 2'h0;
      link_sync_r     <= 2'h0;
      notready_sync_r <= 2'h0;
      conv_sync_r     <= 2'h0;
      brk_meta_r      <= 8'h00;
      brk_raw_r       <= 8'h00;
    end else begin
      lockout_sync_r  <= {lockout_sync_r[0], below_lockout_pin};
      missing_sync_r  <= {missing_sync_r[0], supply_missing_pin};
      low_sync_r      <= {low_sync_r[0], supply_low_pin};
      link_sync_r     <= {link_sync_r[0], link_error_pin};
      notready_sync_r <= {notready_sync_r[0], sense_not_ready_pin};
      conv_sync_r     <= {conv_sync_r[0], converter_fault_pin};
      // raw break pins feed the pending test, so they need their own sync
      brk_meta_r      <= wire_break_pin;
      brk_raw_r       <= brk_meta_r;
    end
  end

  // lockout or link error forces supply flags
  assign supply_missing_now = missing_sync_r[1] | lockout_sync_r[1] | link_sync_r[1];
  assign supply_low_now     = low_sync_r[1] | lockout_sync_r[1] | link_sync_r[1];
  assign internal_now       = {notready_sync_r[1], link_sync_r[1], conv_sync_r[1]};

  // --------------------------------------------------------------------------
  // address latch and read transaction
  // --------------------------------------------------------------------------
  // latch defaults to input level address in parallel mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_latch <= input_status_pkg::ADDR_INPUT_LEVEL;
    end else if (addr_wr) begin
      addr_latch <= addr_in;
    end else if (!parallel_sel) begin
      addr_latch <= input_status_pkg::ADDR_INPUT_LEVEL;
    end
  end

  assign eff_addr  = parallel_sel ? addr_latch : addr_in;
  assign rd_finish = rd_busy_r && rd_end;

  always_comb begin
    cfg_rd_idx = 3'h0;
    cfg_rd_hit = 1'b0;
    cfg_wr_idx = 3'h0;
    cfg_wr_hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (eff_addr == input_status_pkg::ADDR_FILTER_CFG_RD0 + 8'(2 * i)) begin
        cfg_rd_idx = 3'(i);
        cfg_rd_hit = 1'b1;
      end
      if (eff_addr == input_status_pkg::ADDR_FILTER_CFG_WR0 + 8'(2 * i)) begin
        cfg_wr_idx = 3'(i);
        cfg_wr_hit = 1'b1;
      end
    end
  end

  // unmapped addresses and reserved bits read zero
  always_comb begin
    rd_mux = 8'h00;
    if (cfg_rd_hit) begin
      rd_mux = {3'h0, filter_cfg_r[cfg_rd_idx][4:0]};
    end else begin
      unique case (eff_addr)
        input_status_pkg::ADDR_WIRE_BREAK_SUMMARY: rd_mux = wire_break_summary_r;
        input_status_pkg::ADDR_INPUT_LEVEL:        rd_mux = input_level_r;
        input_status_pkg::ADDR_GLOBAL_FAULT:       rd_mux = {5'h00, global_fault_r};
        input_status_pkg::ADDR_INTERNAL_FAULT:     rd_mux = {5'h00, internal_fault_r};
        default:                                   rd_mux = 8'h00;
      endcase
    end
  end

  // freeze the read value at the start of the access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_busy_r <= 1'b0;
      frozen_r  <= 8'h00;
      rd_addr_r <= input_status_pkg::ADDR_INPUT_LEVEL;
      rd_data   <= 8'h00;
    end else if (rd_start) begin
      rd_busy_r <= 1'b1;
      frozen_r  <= rd_mux;
      rd_addr_r <= eff_addr;
      rd_data   <= rd_mux;
    end else if (rd_end) begin
      rd_busy_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // filter configuration
  // --------------------------------------------------------------------------
  // writes via the high address range, reset 0x1F
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        filter_cfg_r[i] <= input_status_pkg::RST_FILTER_CFG;
      end
    end else if (wr_strobe && cfg_wr_hit) begin
      filter_cfg_r[cfg_wr_idx] <= {3'h0, wr_data[4:0]};
    end
  end

  // --------------------------------------------------------------------------
  // status registers
  // --------------------------------------------------------------------------
  // level register follows filtered inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      input_level_r <= input_status_pkg::RST_INPUT_LEVEL;
    end else begin
      input_level_r <= level_filt;
    end
  end

  // clear only read bits with no break present or pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wire_break_summary_r <= input_status_pkg::RST_WIRE_BREAK;
    end else if (rd_finish && rd_addr_r == input_status_pkg::ADDR_WIRE_BREAK_SUMMARY) begin
      wire_break_summary_r <= break_seen
                              | (wire_break_summary_r & ~frozen_r)
                              | (wire_break_summary_r & frozen_r
                                 & (break_filt | brk_raw_r));
    end else begin
      wire_break_summary_r <= wire_break_summary_r | break_seen;
    end
  end

  // sticky global bits, cleared after read when fault gone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      global_fault_r <= input_status_pkg::RST_GLOBAL_FAULT;
    end else begin
      // collective fault is OR of summary
      global_fault_r[input_status_pkg::BIT_COLLECTIVE_FAULT] <= |wire_break_summary_r;
      if (supply_missing_now) begin
        global_fault_r[input_status_pkg::BIT_SUPPLY_MISSING] <= 1'b1;
      end else if (rd_finish && rd_addr_r == input_status_pkg::ADDR_GLOBAL_FAULT
                   && frozen_r[input_status_pkg::BIT_SUPPLY_MISSING]) begin
        global_fault_r[input_status_pkg::BIT_SUPPLY_MISSING] <= 1'b0;
      end
      if (supply_low_now) begin
        global_fault_r[input_status_pkg::BIT_SUPPLY_LOW] <= 1'b1;
      end else if (rd_finish && rd_addr_r == input_status_pkg::ADDR_GLOBAL_FAULT
                   && frozen_r[input_status_pkg::BIT_SUPPLY_LOW]) begin
        global_fault_r[input_status_pkg::BIT_SUPPLY_LOW] <= 1'b0;
      end
    end
  end

  // sticky internal bits; preset at power-up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      internal_fault_r <= input_status_pkg::RST_INTERNAL_FAULT;
    end else if (rd_finish && rd_addr_r == input_status_pkg::ADDR_INTERNAL_FAULT) begin
      // set wins over clear; unread bits keep their value
      internal_fault_r <= internal_now | (internal_fault_r & ~frozen_r[2:0]);
    end else begin
      internal_fault_r <= internal_fault_r | internal_now;
    end
  end

  // --------------------------------------------------------------------------
  // fault pin and status mirrors
  // --------------------------------------------------------------------------
  // fault pin from global and internal bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_n            <= 1'b0;
      global_fault_out   <= 8'h00;
      internal_fault_out <= 8'h00;
    end else begin
      fault_n            <= ~(|global_fault_r | |internal_fault_r);
      global_fault_out   <= {5'h00, global_fault_r};
      internal_fault_out <= {5'h00, internal_fault_r};
    end
  end

endmodule : isolated_input_status_regs

// file: rtl/input_status_pkg.sv
// constants for the isolated input status register bank
package input_status_pkg;

  // --------------------------------------------------------------------------
  // register addresses
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_WIRE_BREAK_SUMMARY = 8'h00;
  localparam logic [7:0] ADDR_INPUT_LEVEL        = 8'h02;
  localparam logic [7:0] ADDR_FILTER_CFG_RD0     = 8'h06;
  localparam logic [7:0] ADDR_FILTER_CFG_WR0     = 8'h86;
  localparam logic [7:0] ADDR_INTERNAL_FAULT     = 8'h16;
  localparam logic [7:0] ADDR_GLOBAL_FAULT       = 8'h04;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int BIT_COLLECTIVE_FAULT  = 0;
  localparam int BIT_SUPPLY_MISSING    = 1;
  localparam int BIT_SUPPLY_LOW        = 2;
  localparam int BIT_LINK_FAULT        = 1;
  localparam int BIT_SENSE_NOT_READY   = 2;
  localparam int BIT_WIRE_BREAK_MASK   = 4;
  localparam int CFG_CODE_MSB          = 3;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] RST_FILTER_CFG     = 8'h1F;
  localparam logic [7:0] RST_INPUT_LEVEL    = 8'h00;
  localparam logic [7:0] RST_WIRE_BREAK     = 8'h00;
  localparam logic [2:0] RST_INTERNAL_FAULT = 3'h6;
  localparam logic [2:0] RST_GLOBAL_FAULT   = 3'h0;

  // --------------------------------------------------------------------------
  // filter times in microseconds and derived cycle counts
  // --------------------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int FILTER_US_0 = 50;
  localparam int FILTER_US_1 = 100;
  localparam int FILTER_US_2 = 400;
  localparam int FILTER_US_3 = 800;
  localparam int FILTER_US_4 = 1600;
  localparam int FILTER_US_5 = 3200;
  localparam int FILTER_US_6 = 10000;
  localparam int FILTER_US_7 = 20000;
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] FILTER_CYC_0 = CNT_W'(FILTER_US_0 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILTER_CYC_1 = CNT_W'(FILTER_US_1 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILTER_CYC_2 = CNT_W'(FILTER_US_2 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILTER_CYC_3 = CNT_W'(FILTER_US_3 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILTER_CYC_4 = CNT_W'(FILTER_US_4 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILTER_CYC_5 = CNT_W'(FILTER_US_5 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILTER_CYC_6 = CNT_W'(FILTER_US_6 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILTER_CYC_7 = CNT_W'(FILTER_US_7 * CLK_MHZ);

endpackage : input_status_pkg

// file: rtl/channel_filter.sv
// one channel: sync, programmable debounce of level and wire-break
`timescale 1ns/10ps
module channel_filter #(
  parameter int SCALE_DIV = 1
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       level_pin,
  input  wire logic       break_pin,
  input  wire logic [3:0] period_code,
  output logic            level_out,
  output logic            break_out
);

  logic [1:0] lvl_sync_r;
  logic [1:0] brk_sync_r;
  logic [input_status_pkg::CNT_W-1:0] limit;
  logic [input_status_pkg::CNT_W-1:0] lvl_cnt_r;
  logic [input_status_pkg::CNT_W-1:0] brk_cnt_r;
  logic bypass;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lvl_sync_r <= 2'h0;
      brk_sync_r <= 2'h0;
    end else begin
      lvl_sync_r <= {lvl_sync_r[0], level_pin};
      brk_sync_r <= {brk_sync_r[0], break_pin};
    end
  end

  always_comb begin
    bypass = period_code[input_status_pkg::CFG_CODE_MSB];
    unique case (period_code[2:0])
      3'h0: limit = input_status_pkg::FILTER_CYC_0;
      3'h1: limit = input_status_pkg::FILTER_CYC_1;
      3'h2: limit = input_status_pkg::FILTER_CYC_2;
      3'h3: limit = input_status_pkg::FILTER_CYC_3;
      3'h4: limit = input_status_pkg::FILTER_CYC_4;
      3'h5: limit = input_status_pkg::FILTER_CYC_5;
      3'h6: limit = input_status_pkg::FILTER_CYC_6;
      3'h7: limit = input_status_pkg::FILTER_CYC_7;
    endcase
  end

  // --------------------------------------------------------------------------
  // debounce: output follows once input differs for the whole filter time
  // --------------------------------------------------------------------------
  // same time both paths
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lvl_cnt_r <= '0;
      level_out <= 1'b0;
    end else if (bypass || lvl_sync_r[1] == level_out) begin
      lvl_cnt_r <= '0;
      level_out <= lvl_sync_r[1];
    end else if (lvl_cnt_r >= limit - 1'b1) begin
      lvl_cnt_r <= '0;
      level_out <= lvl_sync_r[1];
    end else begin
      lvl_cnt_r <= lvl_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brk_cnt_r <= '0;
      break_out <= 1'b0;
    end else if (bypass || brk_sync_r[1] == break_out) begin
      brk_cnt_r <= '0;
      break_out <= brk_sync_r[1];
    end else if (brk_cnt_r >= limit - 1'b1) begin
      brk_cnt_r <= '0;
      break_out <= brk_sync_r[1];
    end else begin
      brk_cnt_r <= brk_cnt_r + 1'b1;
    end
  end

endmodule : channel_filter

// file: tb/input_status_monitor.sv
// port-level checker of the status register bank
`timescale 1ns/10ps
module input_status_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       parallel_sel,
  input wire logic       addr_wr,
  input wire logic [7:0] addr_in,
  input wire logic       rd_start,
  input wire logic       rd_end,
  input wire logic       below_lockout_pin,
  input wire logic       link_error_pin,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] addr_latch,
  input wire logic [7:0] global_fault_out,
  input wire logic [7:0] internal_fault_out,
  input wire logic       fault_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // --------------------------------------------------------------------------
  // relations between ports
  // --------------------------------------------------------------------------
  chk_fault_pin_low: assert property (((global_fault_out | internal_fault_out) != 8'h00) [*3] |-> !fault_n)
    else $error("fault pin high while a fault bit stands");
  chk_fault_pin_high: assert property (((global_fault_out | internal_fault_out) == 8'h00) [*3] |-> fault_n)
    else $error("fault pin low with no fault bit set");
  chk_global_reserved: assert property (global_fault_out[7:3] == 5'h00)
    else $error("global fault upper bits not zero");
  chk_internal_reserved: assert property (internal_fault_out[7:3] == 5'h00)
    else $error("internal fault upper bits not zero");
  chk_cfg_upper_zero: assert property (rd_start && !parallel_sel && addr_in >= 8'h06 && addr_in <= 8'h14
    |=> rd_data[7:5] == 3'h0)
    else $error("filter config read shows reserved bits");
  chk_unmapped_zero: assert property (rd_start && !parallel_sel && addr_in == 8'h01 |=> rd_data == 8'h00)
    else $error("unmapped address read not zero");
  chk_latch_default: assert property (!parallel_sel && !addr_wr |=> addr_latch == 8'h02)
    else $error("address latch left its default");
  chk_lockout_force: assert property (below_lockout_pin [*6] |-> global_fault_out[2:1] == 2'b11)
    else $error("supply flags not forced on lockout");
  chk_link_force: assert property (link_error_pin [*6] |-> global_fault_out[2:1] == 2'b11 && internal_fault_out[1])
    else $error("supply flags not forced on link error");
  chk_preset_after: assert property ($fell(sys_rst) |-> ##[1:2] internal_fault_out[2:1] == 2'b11)
    else $error("internal fault preset missing after reset");
  chk_global_sticky: assert property ($fell(global_fault_out[2])
    |-> $past(rd_end, 1) || $past(rd_end, 2) || $past(rd_end, 3))
    else $error("supply low flag dropped without a read");
endmodule : input_status_monitor

bind isolated_input_status_regs input_status_monitor input_status_monitor_inst (
  .clk(clk), .sys_rst(sys_rst), .parallel_sel(parallel_sel), .addr_wr(addr_wr),
  .addr_in(addr_in), .rd_start(rd_start), .rd_end(rd_end),
  .below_lockout_pin(below_lockout_pin), .link_error_pin(link_error_pin), .rd_data(rd_data),
  .addr_latch(addr_latch), .global_fault_out(global_fault_out),
  .internal_fault_out(internal_fault_out), .fault_n(fault_n));

// file: tb/host_model.sv
// microcontroller side access model of the register bank
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            parallel_sel,
  output logic            addr_wr,
  output logic [7:0]      addr_in,
  output logic            rd_start,
  output logic            rd_end,
  output logic            wr_strobe,
  output logic [7:0]      wr_data
);
  initial begin
    {parallel_sel, addr_wr, rd_start, rd_end, wr_strobe} = 5'h00;
    addr_in = 8'hFF;
    wr_data = 8'hFF;
  end
  // --------------------------------------------------------------------------
  // access tasks; idle buses show the inverse of the last value
  // --------------------------------------------------------------------------
  task automatic par(input logic v);
    @(posedge clk);
    #1;
    parallel_sel = v;
  endtask : par

  task automatic set_addr(input logic [7:0] a);
    @(posedge clk);
    #1;
    addr_in = a;
    addr_wr = 1'b1;
    @(posedge clk);
    #1;
    addr_wr = 1'b0;
    addr_in = ~a;
  endtask : set_addr

  // address held through rd_end; the clear uses the address and bits latched at rd_start
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr_in = a;
    rd_start = 1'b1;
    @(posedge clk);
    #1;
    rd_start = 1'b0;
    rd_end = 1'b1;
    d = rd_data;
    @(posedge clk);
    #1;
    rd_end = 1'b0;
    addr_in = ~a;
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1;
    addr_in = a;
    wr_data = v;
    wr_strobe = 1'b1;
    @(posedge clk);
    #1;
    wr_strobe = 1'b0;
    addr_in = ~a;
    wr_data = ~v;
  endtask : wr
endmodule : host_model

// file: tb/testbench.sv
// self-checking bench of the status register bank
`timescale 1ns/10ps
module testbench;
  localparam logic [7:0] A_SUM = input_status_pkg::ADDR_WIRE_BREAK_SUMMARY;
  localparam logic [7:0] A_LVL = input_status_pkg::ADDR_INPUT_LEVEL;
  localparam logic [7:0] A_GLB = input_status_pkg::ADDR_GLOBAL_FAULT;
  localparam logic [7:0] A_INT = input_status_pkg::ADDR_INTERNAL_FAULT;
  localparam logic [7:0] A_CFG = input_status_pkg::ADDR_FILTER_CFG_RD0;
  localparam logic [7:0] A_CFGW = input_status_pkg::ADDR_FILTER_CFG_WR0;
  logic       clk;
  logic       sys_rst;
  logic       parallel_sel;
  logic       addr_wr;
  logic [7:0] addr_in;
  logic       rd_start;
  logic       rd_end;
  logic       wr_strobe;
  logic [7:0] wr_data;
  logic [7:0] channel_input_pin;
  logic [7:0] wire_break_pin;
  logic       below_lockout_pin;
  logic       supply_missing_pin;
  logic       supply_low_pin;
  logic       link_error_pin;
  logic       sense_not_ready_pin;
  logic       converter_fault_pin;
  logic [7:0] rd_data;
  logic [7:0] addr_latch;
  logic [7:0] global_fault_out;
  logic [7:0] internal_fault_out;
  logic       fault_n;
  logic [7:0] exp_sup [3] = '{8'h02, 8'h04, 8'h06};
  int         mismatches;
  int         n_tests;
  int         i;

  isolated_input_status_regs isolated_input_status_regs_inst (
    .clk(clk), .sys_rst(sys_rst), .parallel_sel(parallel_sel), .addr_wr(addr_wr),
    .addr_in(addr_in), .rd_start(rd_start), .rd_end(rd_end), .wr_strobe(wr_strobe),
    .wr_data(wr_data), .channel_input_pin(channel_input_pin), .wire_break_pin(wire_break_pin),
    .below_lockout_pin(below_lockout_pin), .supply_missing_pin(supply_missing_pin),
    .supply_low_pin(supply_low_pin), .link_error_pin(link_error_pin),
    .sense_not_ready_pin(sense_not_ready_pin), .converter_fault_pin(converter_fault_pin),
    .rd_data(rd_data), .addr_latch(addr_latch), .global_fault_out(global_fault_out),
    .internal_fault_out(internal_fault_out), .fault_n(fault_n));

  host_model host_model_inst (
    .clk(clk), .rd_data(rd_data), .parallel_sel(parallel_sel), .addr_wr(addr_wr),
    .addr_in(addr_in), .rd_start(rd_start), .rd_end(rd_end), .wr_strobe(wr_strobe),
    .wr_data(wr_data));

  always #20 clk = ~clk;

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : hold

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    logic [7:0] d;
    host_model_inst.rd(a, d);
    check(d & m, exp);
  endtask : rc

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // whole sequence needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    mismatches = 0;
    n_tests = 0;
    channel_input_pin = 8'h00;
    wire_break_pin = 8'h00;
    {below_lockout_pin, supply_low_pin, supply_missing_pin} = 3'h0;
    {sense_not_ready_pin, link_error_pin, converter_fault_pin} = 3'h0;
    hold(10);
    sys_rst = 1'b0;
    rc(A_INT, 8'h06);
    rc(A_INT, 8'h00);
    rc(A_SUM, 8'h00);
    rc(A_LVL, 8'h00);
    rc(A_GLB, 8'h00);
    rc(8'h01, 8'h00);
    for (i = 0; i < 8; i++) begin
      rc(A_CFG + 8'(2 * i), 8'h1F);
    end
    $display("test reset values done");
    // reserved bits written high on purpose, read address must not write
    for (i = 0; i < 8; i++) begin
      host_model_inst.wr(A_CFGW + 8'(2 * i), 8'hF8 + 8'(i));
    end
    host_model_inst.wr(A_CFG, 8'h00);
    host_model_inst.wr(A_CFGW + 8'h06, 8'h08);
    for (i = 0; i < 8; i++) begin
      rc(A_CFG + 8'(2 * i), (i == 3) ? 8'h08 : 8'h18 + 8'(i));
    end
    $display("test filter config done");
    channel_input_pin = 8'hA5;
    hold(8);
    rc(A_LVL, 8'hA5);
    channel_input_pin = 8'h5A;
    hold(8);
    rc(A_LVL, 8'h5A);
    $display("test input level done");
    wire_break_pin = 8'h89;
    hold(8);
    rc(A_SUM, 8'h81);
    rc(A_GLB, 8'h01);
    rc(A_SUM, 8'h81);
    wire_break_pin = 8'h00;
    hold(8);
    rc(A_SUM, 8'h81);
    rc(A_SUM, 8'h00);
    hold(4);
    rc(A_GLB, 8'h00);
    $display("test wire break done");
    for (i = 0; i < 3; i++) begin
      {sense_not_ready_pin, link_error_pin, converter_fault_pin} = 3'(1 << i);
      hold(8);
      check({7'h00, fault_n}, 8'h00);
      rc(A_INT, 8'(1 << i), 8'(1 << i));
      {sense_not_ready_pin, link_error_pin, converter_fault_pin} = 3'h0;
      hold(8);
      rc(A_INT, 8'(1 << i), 8'(1 << i));
      rc(A_INT, 8'h00, 8'(1 << i));
    end
    rc(A_GLB, 8'h06);
    rc(A_GLB, 8'h00);
    $display("test internal fault done");
    for (i = 0; i < 3; i++) begin
      {below_lockout_pin, supply_low_pin, supply_missing_pin} = 3'(1 << i);
      hold(8);
      rc(A_GLB, exp_sup[i]);
      {below_lockout_pin, supply_low_pin, supply_missing_pin} = 3'h0;
      hold(8);
      rc(A_GLB, exp_sup[i]);
      rc(A_GLB, 8'h00);
    end
    hold(4);
    check({7'h00, fault_n}, 8'h01);
    $display("test global fault done");
    host_model_inst.par(1'b1);
    rc(A_SUM, 8'h5A);
    host_model_inst.set_addr(A_CFG + 8'h02);
    rc(A_SUM, 8'h19);
    host_model_inst.par(1'b0);
    $display("test parallel latch done");
    sys_rst = 1'b1;
    hold(3);
    sys_rst = 1'b0;
    rc(A_CFG, 8'h1F);
    rc(A_INT, 8'h06);
    $display("test second reset done");
    conclude();
  end
endmodule : testbench
